// ===== core/fpt_pkg.sv
package fpt_pkg;
  // Register word addresses (byte addresses on an 8-bit bus)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHAR = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_PWR_BASE = 8'h10;
  localparam logic [7:0] ADDR_CLK_BASE = 8'h20;
  // Control field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_TYPE_LSB = 1;
  // Object tags
  localparam logic [7:0] TAG_TEMPLATE = 8'ha5;
  localparam logic [7:0] TAG_CHAR = 8'h80;
  localparam logic [7:0] TAG_POWER = 8'h81;
  localparam logic [7:0] TAG_MINCLK = 8'h82;
  localparam logic [7:0] TAG_MEMORY = 8'h83;
  localparam logic [7:0] TAG_DETAILS = 8'h84;
  localparam logic [7:0] TAG_RESERVED = 8'h85;
  localparam logic [7:0] TAG_MAXSIZE = 8'h86;
  localparam logic [1:0] PRIVATE_MARK = 2'h3;
  // Fixed nested lengths
  localparam logic [7:0] LEN_CHAR = 8'h01;
  localparam logic [7:0] LEN_POWER = 8'h03;
  // Value ranges
  localparam logic [7:0] PWR_MIN = 8'h01;
  localparam logic [7:0] PWR_MAX = 8'h3c;
  localparam logic [7:0] FREQ_MIN = 8'h0a;
  localparam logic [7:0] FREQ_NONE = 8'hff;
  // Characteristics byte bit positions
  localparam int CH_STOP = 0;
  localparam int CH_RSV_LO = 1;
  localparam int CH_HIGH = 2;
  localparam int CH_LOW = 3;
  localparam int CH_CLASS_A = 4;
  localparam int CH_CLASS_B = 5;
  localparam int CH_CLASS_C = 6;
  localparam int CH_RSV_HI = 7;
  // Storage depth for repeated objects
  localparam int ENTRIES = 4;
  // Kind of file whose parameters are parsed
  typedef enum logic [2:0] {
    FT_MASTER,
    FT_DIRECTORY,
    FT_APPDIR,
    FT_ELEM_PLAIN,
    FT_ELEM_BERTLV
  } fpt_ftype_t;
endpackage

// ===== core/fpt_parser.sv
// Function
// [R01] Template is tag A5, length, nested objects
// [R02] Private tags after defined ones are tolerated
// [R03] Repeated tags must be contiguous, kept ordered
// [R04] Tag 82 only for application directory
// [R05] Tag 83 required for BER-TLV file
// [R06] Tags 84, 85 only and always BER-TLV
// [R07] Tag 86 optional, BER-TLV file only
// [R08] Several power and clock objects all stored; only the first 4 of each are kept here, later ones dropped
// [R09] Characteristics: tag 80, length 01, one byte
// [R10] b1 set: stop either level, b3/b4 preference
// [R11] b1 clear: stop only at b3/b4 level
// [R12] b5, b6, b7 flag classes A, B, C
// [R13] Card keeps characteristics b8 and b2 zero
// [R14] Power object: tag 81, length 03, three bytes
// [R15] Consumption in mA on b6..b1
// [R16] Consumption 00, FF or above 3C ignored
// [R17] Terminal rescales consumption to current class; not done here, raw value read out
// [R18] Frequency in 0,1 MHz steps, FF none
// [R19] Consumption measured at reference or maximum clock
// [R20] Voltage class byte uses reset class layout
// [R21] Skip unknown tags; flag length overrun
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fpt_parser (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic inValid,
  input wire logic [7:0] inData,
  output logic parseBusy,
  output logic parseDone,
  output logic parseError
);
  import fpt_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum {
    S_IDLE,
    S_TAG,
    S_TLEN,
    S_NTAG,
    S_NLEN,
    S_NVAL,
    S_DONE
  } fpt_state_t;

  typedef struct packed {
    logic [7:0] vclass;
    logic [7:0] value;
    logic [7:0] freq;
  } fpt_pwr_t;

  typedef struct packed {
    fpt_state_t st;
    logic [2:0] fType;
    logic [7:0] tRem;
    logic [7:0] nRem;
    logic [7:0] nTag;
    logic [1:0] nIdx;
    logic [7:0] lastTag;
    logic [6:0] seen;
    logic privSeen;
    logic errOverrun;
    logic errGroup;
    logic errLen;
    logic errPresence;
    logic errReserved;
    logic errOrder;
    logic errTemplate;
    logic [7:0] charByte;
    logic charValid;
    fpt_pwr_t [ENTRIES-1:0] pwr;
    logic [2:0] pwrCnt;
    logic [ENTRIES-1:0][7:0] clk;
    logic [2:0] clkCnt;
    logic [7:0] tmpClass;
    logic [7:0] tmpVal;
    logic [31:0] rdData;
    logic busy;
    logic done;
    logic anyErr;
  } fpt_regs_t;

  fpt_regs_t s_r;
  fpt_regs_t s_nxt;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Index of a defined nested tag inside the seen mask, 7 for others
  function automatic logic [2:0] tagIndex(input logic [7:0] tag);
    if (tag >= TAG_CHAR && tag <= TAG_MAXSIZE)
      return tag[2:0];
    return 3'h7;
  endfunction

  // Consumption byte usable only inside the documented range
  function automatic logic pwrUsable(input logic [7:0] v);
    return (v >= PWR_MIN) && (v <= PWR_MAX); // [R16]
  endfunction

  // Presence check of nested objects against the file kind
  function automatic logic presenceBad(input logic [6:0] seen, input logic [2:0] ft);
    logic ber;
    logic app;
    ber = (ft == 3'(FT_ELEM_BERTLV));
    app = (ft == 3'(FT_APPDIR));
    presenceBad = 1'b0;
    if (seen[1] && !app)
      presenceBad = 1'b1;
    if (seen[2] && !app)
      presenceBad = 1'b1; // [R04]
    if (ber && !seen[3])
      presenceBad = 1'b1;
    if (seen[3] && ft == 3'(FT_ELEM_PLAIN))
      presenceBad = 1'b1; // [R05]
    if (ber != seen[4] || ber != seen[5])
      presenceBad = 1'b1; // [R06]
    if (seen[6] && !ber)
      presenceBad = 1'b1; // [R07]
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [2:0] idx;
    logic [7:0] dec;
    s_nxt = s_r;
    idx = tagIndex(s_r.nTag);
    dec = 8'h00;
    // A GO write to ADDR_CTRL arms the parser; a new run clears all results
    if (regWrite && regAddr == ADDR_CTRL && regWrData[CTRL_GO_BIT])
    begin
      s_nxt = '0;
      s_nxt.fType = regWrData[CTRL_TYPE_LSB +: 3];
      s_nxt.st = S_TAG;
      s_nxt.busy = 1'b1;
    end
    else if (inValid && s_r.busy)
    begin
      if (s_r.st != S_TAG && s_r.st != S_TLEN)
        s_nxt.tRem = s_r.tRem - 8'h01;
      case (s_r.st)
        S_TAG:
        begin
          if (inData == TAG_TEMPLATE) // [R01]
            s_nxt.st = S_TLEN;
          else
          begin
            s_nxt.errTemplate = 1'b1;
            s_nxt.st = S_DONE;
          end
        end
        S_TLEN:
        begin
          s_nxt.tRem = inData;
          s_nxt.st = (inData == 8'h00) ? S_DONE : S_NTAG;
        end
        S_NTAG:
        begin
          s_nxt.nTag = inData;
          s_nxt.lastTag = inData;
          s_nxt.nIdx = 2'h0;
          // A repeat after another tag breaks the grouping
          if (s_r.lastTag != inData && tagIndex(inData) != 3'h7 && s_r.seen[tagIndex(inData)])
            s_nxt.errGroup = 1'b1; // [R03]
          if (inData[7:6] == PRIVATE_MARK)
            s_nxt.privSeen = 1'b1; // [R02]
          else if (s_r.privSeen)
            s_nxt.errOrder = 1'b1; // [R02]
          if (tagIndex(inData) != 3'h7)
            s_nxt.seen[tagIndex(inData)] = 1'b1;
          if (s_r.tRem == 8'h01)
          begin
            s_nxt.errOverrun = 1'b1; // [R21]
            s_nxt.st = S_DONE;
          end
          else
            s_nxt.st = S_NLEN;
        end
        S_NLEN:
        begin
          s_nxt.nRem = inData;
          if ((s_r.nTag == TAG_CHAR && inData != LEN_CHAR) ||
              (s_r.nTag == TAG_POWER && inData != LEN_POWER) ||
              (s_r.nTag == TAG_MINCLK && inData != LEN_CHAR))
            s_nxt.errLen = 1'b1; // [R09] [R14]
          if (inData > s_r.tRem - 8'h01)
          begin
            s_nxt.errOverrun = 1'b1; // [R21]
            s_nxt.st = S_DONE;
          end
          else if (inData == 8'h00)
            s_nxt.st = (s_r.tRem == 8'h01) ? S_DONE : S_NTAG;
          else
            s_nxt.st = S_NVAL;
        end
        S_NVAL:
        begin
          s_nxt.nRem = s_r.nRem - 8'h01;
          s_nxt.nIdx = s_r.nIdx + 2'h1;
          // Unknown and private bodies are only counted through
          if (!s_r.errLen)
          begin
            if (idx == 3'h0)
            begin
              s_nxt.charByte = inData; // [R09]
              s_nxt.charValid = 1'b1;
              if (inData[CH_RSV_HI] || inData[CH_RSV_LO])
                s_nxt.errReserved = 1'b1; // [R13]
            end
            if (idx == 3'h1 && s_r.nIdx == 2'h0)
              s_nxt.tmpClass = inData; // [R20]
            if (idx == 3'h1 && s_r.nIdx == 2'h1)
              s_nxt.tmpVal = inData;
            // Extra occurrences beyond the store are dropped, not overwritten
            if (idx == 3'h1 && s_r.nIdx == 2'h2 && s_r.pwrCnt < 3'(ENTRIES))
            begin
              s_nxt.pwr[s_r.pwrCnt[1:0]] = '{s_r.tmpClass, s_r.tmpVal, inData}; // [R08] [R14]
              s_nxt.pwrCnt = s_r.pwrCnt + 3'h1;
            end
            if (idx == 3'h2 && s_r.clkCnt < 3'(ENTRIES))
            begin
              s_nxt.clk[s_r.clkCnt[1:0]] = inData; // [R08]
              s_nxt.clkCnt = s_r.clkCnt + 3'h1;
            end
          end
          if (s_r.nRem == 8'h01)
            s_nxt.st = (s_r.tRem == 8'h01) ? S_DONE : S_NTAG; // [R21]
        end
        default:
          s_nxt.st = s_r.st;
      endcase
    end
    // Completion: evaluate presence on reaching S_DONE, at template end or after an overrun
    if (s_r.busy && s_r.st == S_DONE)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b1;
      s_nxt.errPresence = !s_r.errTemplate && presenceBad(s_r.seen, s_r.fType);
    end
    s_nxt.anyErr = s_nxt.errOverrun | s_nxt.errGroup | s_nxt.errLen | s_nxt.errPresence |
                   s_nxt.errReserved | s_nxt.errOrder | s_nxt.errTemplate;

    // ****************************************
    // Register reads, data one cycle later
    // ****************************************
    s_nxt.rdData = 32'h0000_0000;
    if (regRead)
    begin
      case (regAddr)
        ADDR_CTRL:
          s_nxt.rdData = {28'h0000000, s_r.fType, 1'b0};
        ADDR_STATUS:
          s_nxt.rdData = {21'h000000, s_r.privSeen, s_r.errTemplate, s_r.errOrder, s_r.errReserved,
                          s_r.errPresence, s_r.errLen, s_r.errGroup, s_r.errOverrun,
                          s_r.anyErr, s_r.done, s_r.busy};
        ADDR_CHAR:
        begin
          // Decoded clock stop view; level codes 11 read as reserved
          dec[0] = s_r.charByte[CH_STOP]; // [R10]
          dec[1] = s_r.charByte[CH_HIGH] && !s_r.charByte[CH_LOW]; // [R10] [R11]
          dec[2] = s_r.charByte[CH_LOW] && !s_r.charByte[CH_HIGH]; // [R10] [R11]
          dec[3] = s_r.charByte[CH_HIGH] && s_r.charByte[CH_LOW];
          dec[4] = !s_r.charByte[CH_STOP] && !s_r.charByte[CH_HIGH] && !s_r.charByte[CH_LOW]; // [R11]
          dec[7:5] = {s_r.charByte[CH_CLASS_C], s_r.charByte[CH_CLASS_B], s_r.charByte[CH_CLASS_A]}; // [R12]
          s_nxt.rdData = {15'h0000, s_r.charValid, dec, s_r.charByte};
        end
        ADDR_COUNT:
          s_nxt.rdData = {17'h00000, s_r.seen, 1'b0, s_r.clkCnt, 1'b0, s_r.pwrCnt};
        default:
        begin
          for (int i = 0; i < ENTRIES; i++)
          begin
            if (regAddr == ADDR_PWR_BASE + 8'(4 * i))
              s_nxt.rdData = {5'h00, pwrUsable(s_r.pwr[i].value), // [R16]
                              (s_r.pwr[i].freq == FREQ_NONE), // [R18] [R19]
                              (s_r.pwr[i].freq >= FREQ_MIN), // [R18]
                              s_r.pwr[i].vclass, 2'h0, s_r.pwr[i].value[5:0], // [R15]
                              s_r.pwr[i].freq};
            if (regAddr == ADDR_CLK_BASE + 8'(4 * i))
              s_nxt.rdData = {22'h000000, (s_r.clk[i] == FREQ_NONE), (s_r.clk[i] >= FREQ_MIN), s_r.clk[i]};
          end
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Outputs straight from flops
  assign regRdData = s_r.rdData;
  assign parseBusy = s_r.busy;
  assign parseDone = s_r.done;
  assign parseError = s_r.anyErr;
endmodule
`default_nettype wire

// ===== verif/fpt_parser_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module fpt_parser_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic inValid,
  input wire logic [7:0] inData,
  input wire logic parseBusy,
  input wire logic parseDone,
  input wire logic parseError
);
  import fpt_pkg::*;
  logic goWr;
  logic [8:0] cnt_r;
  logic [8:0] len_r;
  // Bytes taken since GO; GO wins over a byte in the same cycle
  assign goWr = regWrite && regAddr == ADDR_CTRL && regWrData[CTRL_GO_BIT];
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      len_r <= '0;
    end
    else if (goWr)
      cnt_r <= '0;
    else if (inValid && parseBusy)
    begin
      cnt_r <= cnt_r + 9'h001;
      if (cnt_r == 9'h001)
        len_r <= {1'b0, inData};
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence take_s;
    parseBusy && inValid && !goWr;
  endsequence
  sequence finish_s;
    ##2 (parseDone && !parseBusy);
  endsequence
  tpl_end_a: assert property (take_s ##0 (!parseError && cnt_r > 9'h001 && cnt_r == len_r + 9'h001)
    |-> finish_s) else $error("no done after last byte");
  bad_open_a: assert property (take_s ##0 (cnt_r == 9'h000 && inData != TAG_TEMPLATE)
    |-> finish_s ##0 parseError) else $error("bad opening tag passed");
  go_start_a: assert property (goWr |=> parseBusy && !parseDone && !parseError)
    else $error("GO gave no clean start");
  idle_stay_a: assert property (!parseBusy && !goWr |=> !parseBusy)
    else $error("busy without GO");
  busy_end_a: assert property ($fell(parseBusy) |-> parseDone)
    else $error("busy ended without done");
  done_hold_a: assert property (parseDone && !goWr |=> parseDone)
    else $error("done dropped early");
  one_state_a: assert property (!(parseBusy && parseDone))
    else $error("busy and done together");
  rd_idle_a: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data without read");
  status_view_a: assert property (regRead && regAddr == ADDR_STATUS
    |=> regRdData[2:0] == {$past(parseError), $past(parseDone), $past(parseBusy)}) else $error("status differs");
endmodule
bind fpt_parser fpt_parser_chk i_fpt_parser_chk (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .inValid(inValid),
  .inData(inData), .parseBusy(parseBusy), .parseDone(parseDone), .parseError(parseError));
`default_nettype wire

// ===== verif/fpt_card.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Card side byte source
// ****
module fpt_card (
  input wire logic clk_sys,
  output logic inValid,
  output logic [7:0] inData
);
  import fpt_pkg::*;
  logic [7:0] body[$];
  // Quiet link at start
  initial
  begin
    inValid = 1'b0;
    inData = 8'h00;
  end
  // Raw nested bytes, kept in order of arrival
  task automatic putRaw(input logic [7:0] b[$]);
    foreach (b[i])
      body.push_back(b[i]);
  endtask
  // Reserved bits forced clear, as a real card does
  task automatic putChar(input logic [7:0] c);
    putRaw('{TAG_CHAR, LEN_CHAR, c & 8'h7d});
  endtask
  task automatic putPower(input logic [7:0] cls, input logic [7:0] pw, input logic [7:0] fr);
    putRaw('{TAG_POWER, LEN_POWER, cls, pw, fr});
  endtask
  // Sends body, optionally wrapped; idle data shows the inverse, never the old byte
  task automatic send(input int gap, input bit wrap);
    logic [7:0] t[$];
    t = body;
    body.delete();
    if (wrap)
    begin
      t.push_front(8'(t.size()));
      t.push_front(TAG_TEMPLATE);
    end
    foreach (t[i])
    begin
      @(posedge clk_sys);
      inValid <= 1'b1;
      inData <= t[i];
      repeat (gap)
      begin
        @(posedge clk_sys);
        inValid <= 1'b0;
        inData <= ~t[i];
      end
    end
    @(posedge clk_sys);
    inValid <= 1'b0;
    inData <= ~t[t.size() - 1];
  endtask
endmodule
`default_nettype wire

// ===== verif/fcp_proprietary_template_parser_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Parser testbench
// ****
module test_fcp_proprietary_template_parser;
  import fpt_pkg::*;
  logic clk_sys, arst_n, regWrite, regRead, inValid, parseBusy, parseDone, parseError;
  logic [7:0] regAddr, inData, c;
  logic [7:0] p[3];
  logic [7:0] f[3];
  logic [31:0] regWrData, regRdData, rv;
  integer seed = 49, mismatches = 0, num_checks = 0, cyc = 0;
  fpt_parser i_fpt_parser (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .inValid(inValid), .inData(inData),
    .parseBusy(parseBusy), .parseDone(parseDone), .parseError(parseError));
  fpt_card i_fpt_card (.clk_sys(clk_sys), .inValid(inValid), .inData(inData));
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the longest sequence
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles; an idle edge after each keeps strobes from being rewritten in one step
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    // Data stands for the one cycle after the strobe; taken at its closing edge
    @(posedge clk_sys);
    d = regRdData;
  endtask
  task automatic run(input logic [2:0] kind, input int gap, input bit wrap);
    wrReg(ADDR_CTRL, {28'h0, kind, 1'b1});
    i_fpt_card.send(gap, wrap);
    for (int k = 0; k < 50 && parseDone !== 1'b1; k++)
      @(posedge clk_sys);
    chk("done", 32'h1, {31'h0, parseDone});
  endtask
  task automatic errRun(input logic [2:0] kind, input bit wrap, input int pos);
    run(kind, 1, wrap);
    rdReg(ADDR_STATUS, rv);
    chk("errBit", 32'h1, {31'h0, rv[pos]});
  endtask
  function automatic logic [31:0] charExp(input logic [7:0] b);
    // Both level bits set is reserved, so neither single preference shows then
    return {15'h0, 1'b1, b[6], b[5], b[4], ~(b[0] | b[2] | b[3]), b[2] & b[3], b[3] & ~b[2], b[2] & ~b[3], b[0], b};
  endfunction
  function automatic logic [31:0] pwrExp(input logic [7:0] cl, input logic [7:0] pw, input logic [7:0] fr);
    return {5'h0, pw >= PWR_MIN && pw <= PWR_MAX, fr == FREQ_NONE, fr >= FREQ_MIN, cl, 2'h0, pw[5:0], fr};
  endfunction
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 16; i++)
    begin
      c = 8'($random(seed));
      c[3:0] = 4'(i);
      i_fpt_card.putChar(c);
      run(FT_APPDIR, i % 3, 1'b1);
      rdReg(ADDR_CHAR, rv);
      chk("char", charExp(c & 8'h7d), rv);
    end
    // Repeated power and clock objects with range corners, private tail
    for (int r = 0; r < 4; r++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        p[i] = 8'($random(seed));
        f[i] = 8'($random(seed));
      end
      if (r == 0)
      begin
        p = '{8'h00, 8'h3c, 8'hff};
        f = '{8'h09, 8'h0a, 8'hff};
      end
      if (r == 1)
      begin
        p = '{8'h01, 8'h3d, 8'h40};
        f = '{8'hfe, 8'h00, 8'h0b};
      end
      for (int i = 0; i < 3; i++)
        i_fpt_card.putPower(p[i] ^ f[i], p[i], f[i]);
      i_fpt_card.putRaw('{TAG_MINCLK, 8'h01, f[1], TAG_MINCLK, 8'h01, f[2], 8'hc1, 8'h01, p[0]});
      run(FT_APPDIR, r, 1'b1);
      rdReg(ADDR_COUNT, rv);
      chk("count", 32'h0623, rv);
      for (int i = 0; i < 3; i++)
      begin
        rdReg(ADDR_PWR_BASE + 8'(4 * i), rv);
        chk("power", pwrExp(p[i] ^ f[i], p[i], f[i]), rv);
      end
      for (int i = 0; i < 2; i++)
      begin
        rdReg(ADDR_CLK_BASE + 8'(4 * i), rv);
        chk("minClk", {22'h0, f[i + 1] == FREQ_NONE, f[i + 1] >= FREQ_MIN, f[i + 1]}, rv);
      end
      chk("powerErr", 32'h0, {31'h0, parseError});
    end
    // Memory and size objects against every file kind, then BER-TLV without tag 83, then without tags 84 and 85
    for (int i = 0; i < 7; i++)
    begin
      if (i != 5)
        i_fpt_card.putRaw('{TAG_MEMORY, 8'h02, 8'h00, 8'h10});
      if (i != 6)
        i_fpt_card.putRaw('{TAG_DETAILS, 8'h01, 8'h01, TAG_RESERVED, 8'h02, 8'h00, 8'h00});
      i_fpt_card.putRaw('{TAG_MAXSIZE, 8'h02, 8'h01, 8'h00});
      run(i > 4 ? 3'd4 : 3'(i), i % 2, 1'b1);
      chk("presence", {31'h0, i != 4}, {31'h0, parseError});
    end
    i_fpt_card.putRaw('{TAG_MINCLK, 8'h01, 8'h20});
    errRun(FT_DIRECTORY, 1'b1, 6);
    i_fpt_card.putRaw('{TAG_CHAR, 8'h02, 8'h00, 8'h00});
    errRun(FT_APPDIR, 1'b1, 5);
    i_fpt_card.putRaw('{TAG_POWER, 8'h02, 8'h00, 8'h00});
    errRun(FT_APPDIR, 1'b1, 5);
    i_fpt_card.putPower(8'h10, 8'h05, 8'h0a);
    i_fpt_card.putRaw('{TAG_MINCLK, 8'h01, 8'h20});
    i_fpt_card.putPower(8'h10, 8'h05, 8'h0a);
    errRun(FT_APPDIR, 1'b1, 4);
    i_fpt_card.putRaw('{8'hc1, 8'h01, 8'h00});
    i_fpt_card.putChar(8'h01);
    errRun(FT_APPDIR, 1'b1, 8);
    i_fpt_card.putRaw('{8'h5a, 8'h00});
    errRun(FT_APPDIR, 1'b0, 9);
    i_fpt_card.putRaw('{TAG_CHAR, LEN_CHAR, 8'h82});
    errRun(FT_APPDIR, 1'b1, 7);
    i_fpt_card.putRaw('{TAG_CHAR, 8'h05, 8'h00});
    errRun(FT_APPDIR, 1'b1, 3);
    rdReg(8'hf0, rv);
    chk("unmapped", 32'h0, rv);
    rdReg(ADDR_CTRL, rv);
    chk("ctrl", {28'h0, 3'(FT_APPDIR), 1'b0}, rv);
    final_report();
  end
endmodule
`default_nettype wire
